/* File: design/dma_defs.vh */
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH

// frame bytes
`define DMA_SYNC1          8'ha5
`define DMA_SYNC2          8'h5a
// message identifiers
`define DMA_ID_POWERON     8'h06
`define DMA_ID_BEAM1       8'h01
`define DMA_ID_BEAM2       8'h02
// field limits
`define DMA_FAULT_MAX      16'h07ff
`define DMA_VER_MAX        8'h63
`define DMA_EDGE_MAX       8'h1d
`define DMA_SPEED_MAX      8'h78
// number of range bytes per beam
`define DMA_RANGE_CNT      6'h1e
// link timing
`define DMA_CLK_HZ         10000000
`define DMA_BAUD           57600
`define DMA_BIT_CYC        (`DMA_CLK_HZ / `DMA_BAUD)

`endif

/* File: design/dma_uart_tx.v */
`timescale 1ns/1ns
`default_nettype none
`include "dma_defs.vh"

// 8n1 serial transmitter, one byte at a time
module dma_uart_tx (
   // clock and reset
   input  wire       sys_clk,
   input  wire       reset,
   // byte in
   input  wire       byteValid,
   input  wire [7:0] byteData,
   output wire       byteReady,
   // line
   output wire       txLine
);
   // divider count cut to the counter width on purpose; 173 fits in eight bits
   localparam integer BIT_CYC_I = `DMA_BIT_CYC;
   localparam [7:0]   BIT_CYC   = BIT_CYC_I[7:0];

   reg  [7:0] divCnt_ff;
   reg  [3:0] bitCnt_ff;
   reg  [8:0] shift_ff;
   reg        busy_ff;
   reg        line_ff;
   wire       bitTick;

   // bit-rate enable; restarted on every byte
   assign bitTick   = busy_ff && (divCnt_ff == BIT_CYC - 8'h01);
   assign byteReady = !busy_ff;
   assign txLine    = line_ff;

   // start bit, 8 data lsb first, stop bit
   always @(posedge sys_clk) begin
      if (reset) begin
         divCnt_ff <= 8'h00;
         bitCnt_ff <= 4'h0;
         shift_ff  <= 9'h1ff;
         busy_ff   <= 1'b0;
         line_ff   <= 1'b1;
      end else if (!busy_ff) begin
         divCnt_ff <= 8'h00;
         if (byteValid) begin
            busy_ff   <= 1'b1;
            line_ff   <= 1'b0;
            shift_ff  <= {1'b1, byteData};
            bitCnt_ff <= 4'h0;
         end
      end else if (bitTick) begin
         divCnt_ff <= 8'h00;
         if (bitCnt_ff == 4'h9) begin
            busy_ff <= 1'b0;
         end else begin
            line_ff   <= shift_ff[0];
            shift_ff  <= {1'b1, shift_ff[8:1]};
            bitCnt_ff <= bitCnt_ff + 4'h1;
         end
      end else begin
         divCnt_ff <= divCnt_ff + 8'h01;
      end
   end
endmodule // dma_uart_tx

`default_nettype wire

/* File: design/dma_assembler.v */
`timescale 1ns/1ns
`default_nettype none
`include "dma_defs.vh"

module dma_assembler (
   // clock and reset
   input  wire        sys_clk,
   input  wire        reset,
   // power-on report source
   input  wire        calDone,
   input  wire [15:0] faultWord,
   input  wire [7:0]  fwMajor,
   input  wire [7:0]  fwMinor,
   input  wire [7:0]  fwPatch,
   output reg  [5:0]  rangeIdx,
   output reg         rangeBeam1,
   input  wire [7:0]  rangeData,
   // option
   input  wire        extraBytes,
   // detection requests
   input  wire        beam1Req,
   input  wire [7:0]  beam1Left,
   input  wire [7:0]  beam1Right,
   input  wire        beam2Req,
   input  wire [7:0]  beam2VehId,
   input  wire [7:0]  beam2Left,
   input  wire [7:0]  beam2Right,
   input  wire [7:0]  beam2LeftRange,
   input  wire [7:0]  beam2RightRange,
   input  wire [7:0]  beam2Speed,
   // status
   output reg         busy,
   output reg         powerOnSent,
   output reg  [7:0]  lastVehId,
   // serial line
   output reg         txData
);
   // states, one-hot
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_LOAD = 5'h02;
   localparam [4:0] ST_SEND = 5'h04;
   localparam [4:0] ST_NEXT = 5'h08;
   localparam [4:0] ST_WAIT = 5'h10;
   // message kinds
   localparam [1:0] MK_PON = 2'h0;
   localparam [1:0] MK_B1  = 2'h1;
   localparam [1:0] MK_B2  = 2'h2;

   reg  [4:0] state_ff;
   reg  [1:0] kind_ff;
   reg  [6:0] idx_ff;
   reg  [6:0] last_ff;
   reg  [7:0] csum_ff;
   reg  [7:0] byte_ff;
   reg        valid_ff;
   reg        extra_ff;
   reg  [7:0] vehCnt_ff;
   reg        ponDone_ff;
   reg        calSync1_ff;
   reg        calSync2_ff;
   reg        b1Pend_ff;
   reg        b2Pend_ff;
   // latched request fields
   reg  [7:0] f0_ff, f1_ff, f2_ff, f3_ff, f4_ff, f6_ff;
   reg  [7:0] nxt_byte;
   wire       uartReady;
   wire       uartLine;

   dma_uart_tx u_tx (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .byteValid (valid_ff),
      .byteData  (byte_ff),
      .byteReady (uartReady),
      .txLine    (uartLine)
   );

   // clamp helper; out-of-range values are held at the limit
   function [7:0] clampB;
      input [7:0] v;
      input [7:0] lim;
      begin
         clampB = (v > lim) ? lim : v;
      end
   endfunction

   // byte at frame index: 0,1 sync; 2.. payload; last is checksum
   always @* begin
      nxt_byte = 8'h00;
      if (idx_ff == 7'h00) begin
         nxt_byte = `DMA_SYNC1;
      end else if (idx_ff == 7'h01) begin
         nxt_byte = `DMA_SYNC2;
      end else if (idx_ff == last_ff) begin
         nxt_byte = csum_ff;
      end else begin
         case (kind_ff)
            MK_PON: begin
               if (idx_ff == 7'h02) nxt_byte = `DMA_ID_POWERON;
               else if (idx_ff == 7'h03) nxt_byte = f0_ff;
               else if (idx_ff == 7'h04) nxt_byte = f1_ff;
               else if (idx_ff == 7'h05) nxt_byte = f2_ff;
               else if (idx_ff == 7'h06) nxt_byte = f3_ff;
               else if (idx_ff == 7'h07) nxt_byte = f4_ff;
               else nxt_byte = rangeData;
            end
            MK_B1: begin
               if (idx_ff == 7'h02) nxt_byte = `DMA_ID_BEAM1;
               else if (idx_ff == 7'h03) nxt_byte = f0_ff;
               else if (idx_ff == 7'h04) nxt_byte = f1_ff;
               else nxt_byte = f2_ff;
            end
            MK_B2: begin
               if (idx_ff == 7'h02) nxt_byte = `DMA_ID_BEAM2;
               else if (idx_ff == 7'h03) nxt_byte = f0_ff;
               else if (idx_ff == 7'h04) nxt_byte = f1_ff;
               else if (idx_ff == 7'h05) nxt_byte = f2_ff;
               else if (extra_ff && idx_ff == 7'h06) nxt_byte = f3_ff;
               else if (extra_ff && idx_ff == 7'h07) nxt_byte = f4_ff;
               else nxt_byte = f6_ff;
            end
            default: nxt_byte = 8'h00;
         endcase
      end
   end

   // range table address follows the frame index; beam 2 first
   always @(posedge sys_clk) begin
      if (reset) begin
         rangeIdx   <= 6'h00;
         rangeBeam1 <= 1'b0;
      end else if (idx_ff >= 7'h08 && idx_ff < 7'h26) begin
         rangeIdx   <= idx_ff[5:0] - 6'h08;
         rangeBeam1 <= 1'b0;
      end else if (idx_ff >= 7'h26 && idx_ff < last_ff) begin
         // checksum slot leaves the address alone, so it never passes 29
         rangeIdx   <= idx_ff[5:0] - 6'h26;
         rangeBeam1 <= 1'b1;
      end
   end

   // sequencer: requests are remembered while a frame is on the line
   always @(posedge sys_clk) begin
      if (reset) begin
         state_ff    <= ST_IDLE;
         kind_ff     <= MK_PON;
         idx_ff      <= 7'h00;
         last_ff     <= 7'h00;
         csum_ff     <= 8'h00;
         byte_ff     <= 8'h00;
         valid_ff    <= 1'b0;
         extra_ff    <= 1'b0;
         vehCnt_ff   <= 8'h00;
         ponDone_ff  <= 1'b0;
         calSync1_ff <= 1'b0;
         calSync2_ff <= 1'b0;
         b1Pend_ff   <= 1'b0;
         b2Pend_ff   <= 1'b0;
         f0_ff       <= 8'h00;
         f1_ff       <= 8'h00;
         f2_ff       <= 8'h00;
         f3_ff       <= 8'h00;
         f4_ff       <= 8'h00;
         f6_ff       <= 8'h00;
         busy        <= 1'b0;
         powerOnSent <= 1'b0;
         lastVehId   <= 8'h00;
         txData      <= 1'b1;
      end else begin
         calSync1_ff <= calDone;
         calSync2_ff <= calSync1_ff;
         txData      <= uartLine;
         powerOnSent <= ponDone_ff;
         busy        <= (state_ff != ST_IDLE);
         // a request arriving while one is consumed is kept
         if (beam1Req) b1Pend_ff <= 1'b1;
         if (beam2Req) b2Pend_ff <= 1'b1;
         case (state_ff)
            ST_IDLE: begin
               idx_ff  <= 7'h00;
               csum_ff <= 8'h00;
               if (!ponDone_ff) begin
                  if (calSync2_ff) begin
                     kind_ff <= MK_PON;
                     f0_ff <= (faultWord > `DMA_FAULT_MAX) ? 8'hff : faultWord[7:0];
                     f1_ff <= (faultWord > `DMA_FAULT_MAX) ? 8'h07 : faultWord[15:8];
                     f2_ff <= clampB(fwMajor, `DMA_VER_MAX);
                     f3_ff <= clampB(fwMinor, `DMA_VER_MAX);
                     f4_ff <= clampB(fwPatch, `DMA_VER_MAX);
                     last_ff  <= 7'h08 + {1'b0, `DMA_RANGE_CNT} + {1'b0, `DMA_RANGE_CNT};
                     state_ff <= ST_LOAD;
                  end
               end else if (b1Pend_ff || beam1Req) begin
                  b1Pend_ff <= b1Pend_ff & beam1Req; // a fresh pulse is not lost
                  kind_ff   <= MK_B1;
                  extra_ff  <= extraBytes;
                  f0_ff     <= vehCnt_ff;
                  lastVehId <= vehCnt_ff;
                  vehCnt_ff <= vehCnt_ff + 8'h01;
                  f1_ff     <= clampB(beam1Left, `DMA_EDGE_MAX);
                  f2_ff     <= clampB(beam1Right, `DMA_EDGE_MAX);
                  last_ff   <= extraBytes ? 7'h06 : 7'h04;
                  state_ff  <= ST_LOAD;
               end else if (b2Pend_ff || beam2Req) begin
                  b2Pend_ff <= b2Pend_ff & beam2Req; // a fresh pulse is not lost
                  kind_ff   <= MK_B2;
                  extra_ff  <= extraBytes;
                  f0_ff     <= beam2VehId;
                  f1_ff     <= clampB(beam2Left, `DMA_EDGE_MAX);
                  f2_ff     <= clampB(beam2Right, `DMA_EDGE_MAX);
                  f3_ff     <= beam2LeftRange;
                  f4_ff     <= beam2RightRange;
                  f6_ff     <= clampB(beam2Speed, `DMA_SPEED_MAX);
                  last_ff   <= extraBytes ? 7'h09 : 7'h07;
                  state_ff  <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               // one cycle lets the range address settle
               state_ff <= ST_SEND;
            end
            ST_SEND: begin
               byte_ff  <= nxt_byte;
               valid_ff <= 1'b1;
               if (idx_ff >= 7'h02 && idx_ff != last_ff) begin
                  csum_ff <= csum_ff ^ nxt_byte;
               end
               state_ff <= ST_WAIT;
            end
            ST_WAIT: begin
               // uart takes the byte and goes busy
               if (valid_ff && !uartReady) begin
                  valid_ff <= 1'b0;
               end else if (!valid_ff && uartReady) begin
                  state_ff <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (idx_ff == last_ff) begin
                  if (kind_ff == MK_PON) ponDone_ff <= 1'b1;
                  state_ff <= ST_IDLE;
               end else begin
                  idx_ff   <= idx_ff + 7'h01;
                  state_ff <= ST_LOAD;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
endmodule // dma_assembler

`default_nettype wire

/* File: tb/dma_assembler_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dma_defs.vh"
module dma_assembler_assertions (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   // inputs seen
   input wire logic       calDone,
   // outputs seen
   input wire logic [5:0] rangeIdx,
   input wire logic       busy,
   input wire logic       powerOnSent,
   input wire logic [7:0] lastVehId,
   input wire logic       txData
);
   logic [15:0] lowRun_ff;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // low stretch length, so bit cells can be judged whole
   always @(posedge sys_clk) begin
      if (reset || txData) lowRun_ff <= 16'h0000;
      else lowRun_ff <= lowRun_ff + 16'h0001;
   end
   sequence calQuiet; (!calDone && !busy && !powerOnSent)[*6]; endsequence
   sequence startBit; ##[0:10] !txData; endsequence
   reset_state_a: assert property (
      disable iff (1'b0) reset |=> txData && !busy && !powerOnSent && lastVehId == 8'h00
      && rangeIdx == 6'h00) else $error("state not cleared by reset");
   report_hold_a: assert property (powerOnSent |=> powerOnSent)
      else $error("report flag dropped");
   quiet_line_a: assert property (calQuiet |-> txData)
      else $error("line moved before calibration");
   bit_width_a: assert property ($rose(txData) |-> lowRun_ff != 16'h0000
      && (lowRun_ff % `DMA_BIT_CYC) == 0 && lowRun_ff <= 9 * `DMA_BIT_CYC)
      else $error("low stretch not whole bit cells");
   stop_high_a: assert property ($rose(powerOnSent) |-> txData)
      else $error("report flag before stop bit");
   range_index_a: assert property (rangeIdx <= 6'h1d)
      else $error("range index out of table");
   veh_step_a: assert property (
      !$past(reset) && $changed(lastVehId) |-> lastVehId == $past(lastVehId) + 8'h01)
      else $error("vehicle number skipped");
   busy_start_a: assert property ($rose(busy) |-> startBit)
      else $error("no start bit after busy");
   start_busy_a: assert property ($fell(txData) |-> busy)
      else $error("line fell while idle");
endmodule // dma_assembler_assertions
bind dma_assembler dma_assembler_assertions u_dma_assembler_assertions (.sys_clk(sys_clk),
   .reset(reset), .calDone(calDone), .rangeIdx(rangeIdx), .busy(busy),
   .powerOnSent(powerOnSent), .lastVehId(lastVehId), .txData(txData));
`default_nettype wire

/* File: tb/dma_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dma_defs.vh"
module dma_host_model (
   // clock and line
   input  wire logic       sys_clk,
   input  wire logic       txLine,
   // received bytes
   output var  logic       rxStb,
   output var  logic [7:0] rxByte,
   output var  logic       rxBad
);
   integer i;
   initial begin
      rxStb = 1'b0;
      rxByte = 8'h00;
      rxBad = 1'b0;
   end
   // mid-bit sampler; host has no flow control, so it never stalls the line
   always begin
      @(negedge txLine);
      repeat (`DMA_BIT_CYC / 2) @(posedge sys_clk);
      if (txLine) rxBad <= 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         repeat (`DMA_BIT_CYC) @(posedge sys_clk);
         rxByte[i] <= txLine;
      end
      repeat (`DMA_BIT_CYC) @(posedge sys_clk);
      if (!txLine) rxBad <= 1'b1;
      rxStb <= 1'b1;
      @(posedge sys_clk);
      rxStb <= 1'b0;
   end
endmodule // dma_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        sys_clk = 1'b0, reset = 1'b1, calDone = 1'b0, extraBytes = 1'b0;
   logic        beam1Req = 1'b0, beam2Req = 1'b0, rangeBeam1, busy, powerOnSent, txData;
   logic [15:0] faultWord = 16'hffff;
   logic [7:0]  fwMajor = 8'h96, fwMinor = 8'h63, fwPatch = 8'h00, seed = 8'h12;
   logic [7:0]  beam1Left = 8'h00, beam1Right = 8'h00, beam2VehId = 8'h00;
   logic [7:0]  beam2Left = 8'h00, beam2Right = 8'h00, beam2Speed = 8'h00;
   logic [7:0]  beam2LeftRange = 8'h00, beam2RightRange = 8'h00, lastVehId, rxByte;
   logic [7:0]  r1 [0:29], r2 [0:29], rxq[$], expQ[$];
   logic [5:0]  rangeIdx;
   logic        rxStb, rxBad;
   wire  [7:0]  rangeData = rangeBeam1 ? r1[rangeIdx] : r2[rangeIdx];
   integer      err_total = 0, checks_done = 0, cyc = 0, i, k, n;
   dma_assembler u_dma_assembler (.sys_clk, .reset, .calDone, .faultWord, .fwMajor, .fwMinor,
      .fwPatch, .rangeIdx, .rangeBeam1, .rangeData, .extraBytes, .beam1Req, .beam1Left,
      .beam1Right, .beam2Req, .beam2VehId, .beam2Left, .beam2Right, .beam2LeftRange,
      .beam2RightRange, .beam2Speed, .busy, .powerOnSent, .lastVehId, .txData);
   dma_host_model u_dma_host_model (.sys_clk, .txLine(txData), .rxStb, .rxByte, .rxBad);
   always #50 sys_clk = ~sys_clk;
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   function automatic logic [7:0] lim(input logic [7:0] v, m);
      return v > m ? m : v;
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // collect bytes; a whole frame is 69 bytes of 1730 cycles, hence the ceiling
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (rxStb) rxq.push_back(rxByte);
      if (cyc == 250000) begin
         err_total = err_total + 1;
         complete_run();
      end
   end
   // compare one received frame against the expected payload
   task automatic frame();
      logic [7:0] x;
      x = 8'h00;
      for (k = 0; k < 2000 * (expQ.size() + 3) && rxq.size() < expQ.size() + 3; k++)
         @(posedge sys_clk);
      check("sync1", rxq[0], 8'ha5);
      check("sync2", rxq[1], 8'h5a);
      foreach (expQ[j]) begin
         check("payload", rxq[j + 2], expQ[j]);
         x ^= expQ[j];
      end
      check("checksum", rxq[expQ.size() + 2], x);
      rxq.delete();
      expQ.delete();
   endtask
   initial begin
      for (i = 0; i < 30; i++) begin
         r1[i] = rnd();
         r2[i] = rnd();
      end
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      beam1Req <= 1'b1;
      @(posedge sys_clk);
      beam1Req <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check("early line", txData, 1'b1);
      check("early flag", powerOnSent, 1'b0);
      calDone <= 1'b1;
      expQ = {8'h06, 8'hff, 8'h07, 8'h63, 8'h63, 8'h00};
      for (i = 0; i < 30; i++) expQ.push_back(r2[i]);
      for (i = 0; i < 30; i++) expQ.push_back(r1[i]);
      frame();
      repeat (200) @(posedge sys_clk);
      check("report flag", powerOnSent, 1'b1);
      expQ = {8'h01, 8'h00};
      frame();
      check("vehicle", lastVehId, 8'h00);
      // both beams at once: beam 1 must go first
      for (n = 1; n < 3; n++) begin
         @(posedge sys_clk);
         extraBytes <= (n == 1);
         {beam1Left, beam1Right, beam2Left, beam2Right} <= {rnd(), rnd(), rnd(), rnd()};
         {beam2LeftRange, beam2RightRange, beam2Speed} <= {rnd(), rnd(), rnd()};
         beam2VehId <= n[7:0];
         beam1Req <= 1'b1;
         beam2Req <= 1'b1;
         @(posedge sys_clk);
         beam1Req <= 1'b0;
         beam2Req <= 1'b0;
         expQ = {8'h01, n[7:0]};
         if (extraBytes) expQ = {expQ, lim(beam1Left, 8'h1d), lim(beam1Right, 8'h1d)};
         frame();
         check("vehicle", lastVehId, n[7:0]);
         expQ = {8'h02, n[7:0], lim(beam2Left, 8'h1d), lim(beam2Right, 8'h1d)};
         if (extraBytes) expQ = {expQ, beam2LeftRange, beam2RightRange};
         expQ.push_back(lim(beam2Speed, 8'h78));
         frame();
      end
      repeat (400) @(posedge sys_clk);
      check("idle busy", busy, 1'b0);
      check("framing", rxBad, 1'b0);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
